/* File: src/cls_pkg.sv */
/*
 * Shared constants and types of the cache line-state controller: register map, field positions, reset values,
 * state and operation encodings, snoop codes and the request carriers.
 * Assumes a 32-bit APB register bus and a 16-byte line of four long words.
 */
package cls_pkg;

	// Cache geometry.
	localparam int WAYS       = 4;
	localparam int LINE_WORDS = 4;
	localparam logic [1:0] LAST_BEAT = 2'h3;

	// Register byte offsets on the APB port.
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_HITS   = 12'h008;
	localparam logic [11:0] OFF_MISSES = 12'h00C;

	// Control register fields and reset values.
	localparam int CTRL_SNOOP_EN_BIT = 0;
	localparam int CTRL_FLUSH_BIT    = 1;
	localparam logic CTRL_SNOOP_EN_RESET = 1'b1;

	// Status register fields.
	localparam int STAT_STATE_LSB  = 0;
	localparam int STAT_HBUF_BIT   = 3;
	localparam int STAT_FLUSH_BIT  = 4;

	// Replacement generator seed.
	localparam logic [7:0] LFSR_SEED = 8'hA5;

	// Snoop control codes.
	localparam logic [1:0] SC_LEAVE_DIRTY = 2'h1;
	localparam logic [1:0] SC_INVALIDATE  = 2'h2;

	// Values of the cache policy field.
	localparam logic POLICY_WRITETHROUGH = 1'b0;
	localparam logic POLICY_COPYBACK     = 1'b1;

	typedef enum logic [1:0] {
		OP_ACCESS                        = 2'b00,
		OP_CACHE_INVALIDATE_OP           = 2'b01,
		OP_CACHE_WRITEBACK_INVALIDATE_OP = 2'b10
	} cls_op_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_FILL   = 3'b001,
		ST_FINISH = 3'b010,
		ST_WBACK  = 3'b011,
		ST_WTHRU  = 3'b100
	} cls_state_t;

	typedef struct packed {
		logic        is_instr;
		logic        write;
		logic        cache_policy_field;
		cls_op_t     op;
		logic [31:0] addr;
		logic [31:0] wdata;
	} cls_iu_req_t;

	typedef struct packed {
		logic        write;
		logic [1:0]  ctrl;
		logic [31:0] addr;
	} cls_snp_req_t;

	typedef struct packed {
		logic        write;
		logic        line;
		logic [31:0] addr;
		logic [31:0] wdata;
	} cls_bus_cmd_t;

endpackage

/* File: src/cls_way_lookup.sv */
/*
 * Tag match and free-way search over one set of a four-way cache.
 * Assumes tags and valid bits of the addressed set are presented combinationally.
 */
`timescale 1ns/1ps
module cls_way_lookup #(
	parameter int WAYS_N = 4,
	parameter int TAG_W  = 26
) (
	input  logic [WAYS_N-1:0][TAG_W-1:0]  tags,
	input  logic [WAYS_N-1:0]             valid,
	input  logic [TAG_W-1:0]              tag,
	output logic                          hit,
	output logic [$clog2(WAYS_N)-1:0]     hit_way,
	output logic                          free,
	output logic [$clog2(WAYS_N)-1:0]     free_way
);
	// Lowest-numbered way wins in both searches; the loop walks down so the last match kept is the lowest.
	always_comb begin
		hit      = 1'b0;
		hit_way  = '0;
		free     = 1'b0;
		free_way = '0;
		for (int w = WAYS_N - 1; w >= 0; w--) begin
			if (valid[w] && tags[w] == tag) begin
				hit     = 1'b1;
				hit_way = ($clog2(WAYS_N))'(w);
			end
			if (!valid[w]) begin
				free     = 1'b1;
				free_way = ($clog2(WAYS_N))'(w);
			end
		end
	end
endmodule

/* File: src/cls_controller.sv */
/*
 * Line-state controller for a four-way instruction cache and a four-way data cache with a dirty-line
 * holding buffer, a bus-controller request port, a snoop port and an APB register slave.
 * Assumes integer_unit, bus controller and snooper run on pclk; bus_ack arrives only while bus_req is high.
 */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Data lines are invalid, valid or dirty; instruction lines only invalid or valid.
// - Each data access follows writethrough or copyback as its policy field says.
// - Read misses and copyback write misses fill a whole line from memory.
// - A fill uses an invalid way first, then writes tag, data and sets valid.
// - With all ways occupied, a pseudorandom pick among four ways is the victim.
// - A dirty victim goes to the holding buffer and is written after the fill.
// - Snoops check the holding buffer as well as both caches.
// - A read miss fetches, delivers and installs the line, leaving it valid.
// - A read hit returns data with no memory access and no state change.
// - A read miss with dirty victim buffers, fills, supplies, then writes back.
// - A copyback write miss fills, merges and marks modified words dirty.
// - With a dirty victim that miss also buffers first and writes back last.
// - A writethrough write miss only writes memory, allocating nothing.
// - A copyback write hit updates the cache only and marks the word dirty.
// - A writethrough write hit updates cache and memory, state unchanged.
// - A writethrough hit on a dirty line keeps its word dirty bits as they were.
// - Instruction invalidate or push clears a valid line; invalid lines untouched.
// - Data invalidate clears valid and dirty lines and drops dirty data.
// - The instruction cache ignores snoop reads with control 01.
// - A snoop read hit with control 10 invalidates an instruction line.
// - A snoop write hit with control 01 or 10 invalidates an instruction line.
// - Snoop read 01 keeps data lines; a dirty one inhibits memory and sources data.
// - Data push writes back a dirty line then invalidates; valid lines just invalidate.
// - Snoop read 10 invalidates data lines; a dirty one also inhibits and sources.
module cls_controller
	import cls_pkg::*;
#(
	parameter int SETS = 4
) (
	input  logic          pclk,
	input  logic          presetn,
	input  logic          psel,
	input  logic          penable,
	input  logic          pwrite,
	input  logic [11:0]   paddr,
	input  logic [31:0]   pwdata,
	output logic [31:0]   prdata,
	output logic          pready,
	output logic          pslverr,
	input  logic          iu_req_valid,
	input  cls_iu_req_t   iu_req,
	output logic          iu_ready,
	output logic          iu_done,
	output logic [31:0]   iu_rdata,
	output logic          bus_req,
	output cls_bus_cmd_t  bus_cmd,
	input  logic          bus_ack,
	input  logic [31:0]   bus_rdata,
	input  logic          snp_valid,
	input  cls_snp_req_t  snp_req,
	output logic          snp_ready,
	output logic          snp_done,
	output logic          memory_inhibit,
	output logic [31:0]   snp_rdata
);
	localparam int SB = $clog2(SETS);
	localparam int TW = 28 - SB;

	generate
		if (SETS < 2 || (SETS & (SETS - 1)) != 0 || WAYS != 4 || LINE_WORDS != 4) begin : g_bad_cfg
			$error("cls_controller: SETS must be a power of two of at least 2");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////////////////////////////
	// Storage. Valid and dirty bits are reset; tags and data need not be.
	logic [WAYS-1:0][TW-1:0]                d_tag  [SETS];
	logic [WAYS-1:0][TW-1:0]                i_tag  [SETS];
	logic [WAYS-1:0][LINE_WORDS-1:0][31:0]  d_data [SETS];
	logic [WAYS-1:0][LINE_WORDS-1:0][31:0]  i_data [SETS];
	logic [WAYS-1:0]                        d_val  [SETS];
	logic [WAYS-1:0]                        i_val  [SETS];
	logic [WAYS-1:0][LINE_WORDS-1:0]        word_dirty_bits [SETS];

	cls_state_t                  state_reg, state_next;
	cls_iu_req_t                 req_reg, req_next;
	cls_bus_cmd_t                bus_cmd_reg, cmd_next;
	logic                        bus_req_reg, bus_req_next;
	logic [1:0]                  beat_reg, beat_next;
	logic [1:0]                  way_reg;
	logic [7:0]                  lfsr_reg;
	logic                        hbuf_valid_reg;
	logic [27:0]                 hbuf_line_reg, hb_line_next;
	logic [LINE_WORDS-1:0][31:0] hbuf_data_reg, hb_data_next;
	logic [LINE_WORDS-1:0]       hbuf_dirty_reg, hb_dirty_next;
	logic                        snoop_en_reg, flush_pend_reg;
	logic [31:0]                 hits_reg, misses_reg, prdata_reg, iu_rdata_reg, snp_rdata_reg;
	logic                        iu_done_reg, done_next, snp_done_reg, inhibit_reg;

	////////////////////////////////////////////////////////////////////////////////////////////////////////
	// Address fields of the processor request and of the snoop.
	wire [SB-1:0] iu_set  = iu_req.addr[4 +: SB];
	wire [TW-1:0] iu_tag  = iu_req.addr[31 -: TW];
	wire [1:0]    iu_word = iu_req.addr[3:2];
	wire [SB-1:0] rq_set  = req_reg.addr[4 +: SB];
	wire [1:0]    rq_word = req_reg.addr[3:2];
	wire [SB-1:0] sn_set  = snp_req.addr[4 +: SB];
	wire [TW-1:0] sn_tag  = snp_req.addr[31 -: TW];
	wire [1:0]    sn_word = snp_req.addr[3:2];

	logic       ud_hit, ui_hit, ud_free, ui_free, sd_hit, si_hit;
	logic [1:0] ud_way, ui_way, ud_fway, ui_fway, sd_way, si_way;

	cls_way_lookup #(.WAYS_N(WAYS), .TAG_W(TW)) u_iu_d (
		.tags(d_tag[iu_set]), .valid(d_val[iu_set]), .tag(iu_tag),
		.hit(ud_hit), .hit_way(ud_way), .free(ud_free), .free_way(ud_fway));
	cls_way_lookup #(.WAYS_N(WAYS), .TAG_W(TW)) u_iu_i (
		.tags(i_tag[iu_set]), .valid(i_val[iu_set]), .tag(iu_tag),
		.hit(ui_hit), .hit_way(ui_way), .free(ui_free), .free_way(ui_fway));
	cls_way_lookup #(.WAYS_N(WAYS), .TAG_W(TW)) u_sn_d (
		.tags(d_tag[sn_set]), .valid(d_val[sn_set]), .tag(sn_tag),
		.hit(sd_hit), .hit_way(sd_way), .free(), .free_way());
	cls_way_lookup #(.WAYS_N(WAYS), .TAG_W(TW)) u_sn_i (
		.tags(i_tag[sn_set]), .valid(i_val[sn_set]), .tag(sn_tag),
		.hit(si_hit), .hit_way(si_way), .free(), .free_way());

	////////////////////////////////////////////////////////////////////////////////////////////////////////
	// Snoop decode. Snoops win over the processor in idle so the arrays never see two writers.
	wire sn_take   = snp_valid && snp_ready;
	wire sn_act    = sn_take && snoop_en_reg;
	wire sn_dirty  = |word_dirty_bits[sn_set][sd_way];
	wire sn_bh     = hbuf_valid_reg && hbuf_line_reg == snp_req.addr[31:4];
	wire sn_code   = snp_req.ctrl == SC_LEAVE_DIRTY || snp_req.ctrl == SC_INVALIDATE;
	wire sn_src    = sn_act && !snp_req.write && sn_code && ((sd_hit && sn_dirty) || sn_bh);
	wire sn_d_inv  = sn_act && !snp_req.write && sd_hit && snp_req.ctrl == SC_INVALIDATE;
	// A read with code 01 never reaches the instruction cache.
	wire sn_i_inv  = sn_act && si_hit && (snp_req.ctrl == SC_INVALIDATE
	                 || (snp_req.write && snp_req.ctrl == SC_LEAVE_DIRTY));
	wire [31:0] sn_word_data = sn_bh ? hbuf_data_reg[sn_word] : d_data[sn_set][sd_way][sn_word];

	assign snp_ready = state_reg == ST_IDLE || state_reg == ST_WBACK;

	////////////////////////////////////////////////////////////////////////////////////////////////////////
	// Processor request decode, only meaningful in idle.
	assign iu_ready = state_reg == ST_IDLE && !sn_take && !flush_pend_reg;

	wire       take     = iu_req_valid && iu_ready;
	wire       instr    = iu_req.is_instr;
	wire       wr       = iu_req.write && !instr;
	wire       cb       = iu_req.cache_policy_field == POLICY_COPYBACK;
	wire       acc      = iu_req.op == OP_ACCESS;
	wire       hit      = instr ? ui_hit : ud_hit;
	wire [1:0] hway     = instr ? ui_way : ud_way;
	wire       free     = instr ? ui_free : ud_free;
	wire [1:0] vway     = free ? (instr ? ui_fway : ud_fway) : lfsr_reg[1:0];
	wire       h_dirty  = !instr && |word_dirty_bits[iu_set][hway];
	wire       v_dirty  = !instr && d_val[iu_set][vway] && |word_dirty_bits[iu_set][vway];
	wire       ev_clear = take && !acc && hit;
	wire       ev_push  = ev_clear && iu_req.op == OP_CACHE_WRITEBACK_INVALIDATE_OP && h_dirty;
	wire       ev_alloc = take && acc && !hit && (!wr || cb);
	wire       ev_whit  = take && acc && hit && wr;
	wire       ev_wt    = take && acc && wr && !cb;
	wire       hb_load  = ev_push || (ev_alloc && v_dirty);
	wire [1:0] lway     = ev_push ? hway : vway;
	wire       fill_ack = state_reg == ST_FILL && bus_ack;
	wire       wb_step  = state_reg == ST_WBACK && (bus_ack || !hbuf_dirty_reg[beat_reg]);
	wire       wb_end   = wb_step && beat_reg == LAST_BEAT;
	wire       merge    = req_reg.write && !req_reg.is_instr;
	wire       flush_do = state_reg == ST_IDLE && flush_pend_reg && !sn_take;

	assign hb_line_next  = hb_load ? {d_tag[iu_set][lway], iu_set} : hbuf_line_reg;
	assign hb_data_next  = hb_load ? d_data[iu_set][lway] : hbuf_data_reg;
	assign hb_dirty_next = hb_load ? word_dirty_bits[iu_set][lway] : hbuf_dirty_reg;
	assign req_next      = take ? iu_req : req_reg;

	////////////////////////////////////////////////////////////////////////////////////////////////////////
	// Sequencer. The buffered victim is only written after the fill completes.
	always_comb begin
		state_next = state_reg;
		beat_next  = beat_reg;
		done_next  = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				beat_next = 2'h0;
				if (ev_alloc) begin
					state_next = ST_FILL;
				end else if (ev_push) begin
					state_next = ST_WBACK;
				end else if (ev_wt) begin
					state_next = ST_WTHRU;
				end else begin
					done_next = take;
				end
			end
			ST_FILL: begin
				if (bus_ack) begin
					beat_next = beat_reg + 2'h1;
					if (beat_reg == LAST_BEAT) begin
						state_next = ST_FINISH;
					end
				end
			end
			ST_FINISH: begin
				done_next  = 1'b1;
				beat_next  = 2'h0;
				state_next = hbuf_valid_reg ? ST_WBACK : ST_IDLE;
			end
			ST_WBACK: begin
				if (wb_step) begin
					beat_next = beat_reg + 2'h1;
					if (beat_reg == LAST_BEAT) begin
						state_next = ST_IDLE;
						done_next  = req_reg.op == OP_CACHE_WRITEBACK_INVALIDATE_OP;
					end
				end
			end
			ST_WTHRU: begin
				if (bus_ack) begin
					state_next = ST_IDLE;
					done_next  = 1'b1;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Bus command for the next cycle; only dirty long words of the buffered line are sent.
	always_comb begin
		cmd_next     = '0;
		bus_req_next = 1'b0;
		case (state_next)
			ST_FILL: begin
				bus_req_next = 1'b1;
				cmd_next.line = 1'b1;
				cmd_next.addr = {req_next.addr[31:4], beat_next, 2'b00};
			end
			ST_WTHRU: begin
				bus_req_next   = 1'b1;
				cmd_next.write = 1'b1;
				cmd_next.addr  = req_next.addr;
				cmd_next.wdata = req_next.wdata;
			end
			ST_WBACK: begin
				bus_req_next   = hb_dirty_next[beat_next];
				cmd_next.write = 1'b1;
				cmd_next.addr  = {hb_line_next, beat_next, 2'b00};
				cmd_next.wdata = hb_data_next[beat_next];
			end
			default: begin
				cmd_next = '0;
			end
		endcase
	end

	// Control registers of the sequencer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= ST_IDLE;
			beat_reg    <= 2'h0;
			req_reg     <= '0;
			bus_req_reg <= 1'b0;
			bus_cmd_reg <= '0;
			iu_done_reg <= 1'b0;
			lfsr_reg    <= LFSR_SEED;
		end else begin
			state_reg   <= state_next;
			beat_reg    <= beat_next;
			req_reg     <= req_next;
			bus_req_reg <= bus_req_next;
			bus_cmd_reg <= cmd_next;
			iu_done_reg <= done_next;
			lfsr_reg    <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
		end
	end

	// Victim way and data returned to the processor.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			way_reg      <= 2'h0;
			iu_rdata_reg <= '0;
		end else begin
			if (ev_alloc) begin
				way_reg <= vway;
			end
			if (take && acc && hit && !wr) begin
				iu_rdata_reg <= instr ? i_data[iu_set][hway][iu_word] : d_data[iu_set][hway][iu_word];
			end else if (fill_ack && beat_reg == rq_word) begin
				iu_rdata_reg <= bus_rdata;
			end
		end
	end

	// Holding buffer for a dirty line waiting to be copied back.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hbuf_valid_reg <= 1'b0;
			hbuf_line_reg  <= '0;
			hbuf_data_reg  <= '0;
			hbuf_dirty_reg <= '0;
		end else begin
			hbuf_valid_reg <= hb_load || (hbuf_valid_reg && !wb_end);
			hbuf_line_reg  <= hb_line_next;
			hbuf_data_reg  <= hb_data_next;
			hbuf_dirty_reg <= hb_dirty_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////////
	// Line state bits. Events are mutually exclusive per cycle by the take and snoop arbitration.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int s = 0; s < SETS; s++) begin
				d_val[s]           <= '0;
				i_val[s]           <= '0;
				word_dirty_bits[s] <= '0;
			end
		end else if (flush_do) begin
			for (int s = 0; s < SETS; s++) begin
				d_val[s]           <= '0;
				i_val[s]           <= '0;
				word_dirty_bits[s] <= '0;
			end
		end else begin
			if (ev_clear && instr) begin
				i_val[iu_set][hway] <= 1'b0;
			end else if (ev_clear) begin
				d_val[iu_set][hway]           <= 1'b0;
				word_dirty_bits[iu_set][hway] <= '0;
			end
			if (ev_alloc && instr) begin
				i_val[iu_set][vway] <= 1'b0;
			end else if (ev_alloc) begin
				d_val[iu_set][vway]           <= 1'b0;
				word_dirty_bits[iu_set][vway] <= '0;
			end
			// A writethrough hit leaves the dirty bits alone, even on a dirty line.
			if (ev_whit && cb) begin
				word_dirty_bits[iu_set][hway][iu_word] <= 1'b1;
			end
			if (state_reg == ST_FINISH && req_reg.is_instr) begin
				i_val[rq_set][way_reg] <= 1'b1;
			end else if (state_reg == ST_FINISH) begin
				d_val[rq_set][way_reg]                    <= 1'b1;
				word_dirty_bits[rq_set][way_reg]          <= '0;
				word_dirty_bits[rq_set][way_reg][rq_word] <= merge;
			end
			if (sn_i_inv) begin
				i_val[sn_set][si_way] <= 1'b0;
			end
			if (sn_d_inv) begin
				d_val[sn_set][sd_way]           <= 1'b0;
				word_dirty_bits[sn_set][sd_way] <= '0;
			end
		end
	end

	// Tags and line data; the write merge lands one cycle after the last fill beat.
	always_ff @(posedge pclk) begin
		if (ev_whit) begin
			d_data[iu_set][hway][iu_word] <= iu_req.wdata;
		end
		if (fill_ack && req_reg.is_instr) begin
			i_data[rq_set][way_reg][beat_reg] <= bus_rdata;
			i_tag[rq_set][way_reg]            <= req_reg.addr[31 -: TW];
		end else if (fill_ack) begin
			d_data[rq_set][way_reg][beat_reg] <= bus_rdata;
			d_tag[rq_set][way_reg]            <= req_reg.addr[31 -: TW];
		end
		if (state_reg == ST_FINISH && merge) begin
			d_data[rq_set][way_reg][rq_word] <= req_reg.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////////
	// Snoop answer, one cycle after the snoop is taken.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snp_done_reg  <= 1'b0;
			inhibit_reg   <= 1'b0;
			snp_rdata_reg <= '0;
		end else begin
			snp_done_reg  <= sn_take;
			inhibit_reg   <= sn_src;
			snp_rdata_reg <= sn_src ? sn_word_data : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////////
	// APB slave. Zero wait states; read data is latched in the setup cycle.
	wire apb_wr   = psel && penable && pwrite;
	wire is_ctrl  = paddr == OFF_CTRL;
	wire mapped   = is_ctrl || paddr == OFF_STATUS || paddr == OFF_HITS || paddr == OFF_MISSES;
	wire flush_wr = apb_wr && is_ctrl && pwdata[CTRL_FLUSH_BIT];

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (is_ctrl) begin
			rd_mux[CTRL_SNOOP_EN_BIT] = snoop_en_reg;
		end else if (paddr == OFF_STATUS) begin
			rd_mux[STAT_STATE_LSB +: 3] = state_reg;
			rd_mux[STAT_HBUF_BIT]       = hbuf_valid_reg;
			rd_mux[STAT_FLUSH_BIT]      = flush_pend_reg;
		end else if (paddr == OFF_HITS) begin
			rd_mux = hits_reg;
		end else if (paddr == OFF_MISSES) begin
			rd_mux = misses_reg;
		end
	end

	// A flush request written in the cycle the previous one completes is kept, not lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snoop_en_reg   <= CTRL_SNOOP_EN_RESET;
			flush_pend_reg <= 1'b0;
			prdata_reg     <= '0;
			hits_reg       <= '0;
			misses_reg     <= '0;
		end else begin
			if (apb_wr && is_ctrl) begin
				snoop_en_reg <= pwdata[CTRL_SNOOP_EN_BIT];
			end
			flush_pend_reg <= flush_wr || (flush_pend_reg && !flush_do);
			if (psel && !penable) begin
				prdata_reg <= rd_mux;
			end
			if (take && acc && hit) begin
				hits_reg <= hits_reg + 32'h1;
			end else if (take && acc) begin
				misses_reg <= misses_reg + 32'h1;
			end
		end
	end

	assign prdata         = prdata_reg;
	assign pready         = 1'b1;
	assign pslverr        = psel && penable && !mapped;
	assign iu_done        = iu_done_reg;
	assign iu_rdata       = iu_rdata_reg;
	assign bus_req        = bus_req_reg;
	assign bus_cmd        = bus_cmd_reg;
	assign snp_done       = snp_done_reg;
	assign memory_inhibit = inhibit_reg;
	assign snp_rdata      = snp_rdata_reg;
endmodule

/* File: sim/cls_controller_assertions.sv */
/* Port checker for cls_controller.
   Assumes it is bound into the controller from tb_top. */
`timescale 1ns/1ps
module cls_chk
	import cls_pkg::*;
(
	input logic         pclk,
	input logic         presetn,
	input logic         psel,
	input logic         penable,
	input logic [11:0]  paddr,
	input logic         pready,
	input logic         pslverr,
	input logic         iu_req_valid,
	input cls_iu_req_t  iu_req,
	input logic         iu_ready,
	input logic         iu_done,
	input logic         bus_req,
	input cls_bus_cmd_t bus_cmd,
	input logic         bus_ack,
	input logic         snp_valid,
	input logic         snp_ready,
	input logic         snp_done,
	input logic         memory_inhibit,
	input logic [31:0]  snp_rdata
);
	////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Register slave and snoop answer timing.
	a_apb_no_wait: assert property (pready) else $error("pready low");
	a_apb_unmapped: assert property (psel && penable && paddr[11:4] != 8'h00 |-> pslverr) else $error("no slverr");
	a_snoop_answer: assert property (snp_valid && snp_ready |=> snp_done) else $error("snoop unanswered");
	a_snoop_cause: assert property (snp_done |-> $past(snp_valid && snp_ready)) else $error("stray done");
	a_inhibit_data: assert property (!memory_inhibit |-> snp_rdata == 32'h0) else $error("data leak");
	// Beats hold until acknowledged; a line beat is never a write.
	a_bus_hold: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_cmd)) else $error("beat lost");
	a_fill_read: assert property (bus_req && bus_cmd.line |-> !bus_cmd.write) else $error("fill writes");
	a_wthru_write: assert property (iu_req_valid && iu_ready && iu_req.write && !iu_req.is_instr
		&& iu_req.op == OP_ACCESS && iu_req.cache_policy_field == POLICY_WRITETHROUGH
		|=> bus_req && bus_cmd.write && bus_cmd.wdata == $past(iu_req.wdata)) else $error("no write");
	cover property (memory_inhibit);
	cover property (bus_req && bus_ack && bus_cmd.write);
	cover property (iu_done && !bus_req);
endmodule

/* File: sim/cls_bus_model.sv */
/* Bus controller model: answers beats alternately at once and after one wait.
   Assumes it shares pclk with the controller. */
`timescale 1ns/1ps
module cls_bus_model
	import cls_pkg::*;
(
	input  logic         pclk,
	input  logic         presetn,
	input  logic         bus_req,
	input  cls_bus_cmd_t bus_cmd,
	output logic         bus_ack,
	output logic [31:0]  bus_rdata,
	output int           beats,
	output logic [31:0]  wr_data
);
	logic slow;
	logic waited;
	// Off-beat data is inverted so a stale word can never pass for a good one.
	assign bus_rdata = bus_ack ? bus_cmd.addr ^ 32'h5A000000 : ~bus_cmd.addr;
	// Every other beat stalls one cycle; beats are counted and the wdata of the last acknowledged beat, read or write, is kept.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{bus_ack, waited, slow, beats, wr_data} <= '0;
		end else begin
			bus_ack <= bus_req && !bus_ack && (waited || !slow);
			waited <= bus_req && !bus_ack && !waited && slow;
			if (bus_req && bus_ack) begin
				slow <= !slow;
				beats <= beats + 1;
				wr_data <= bus_cmd.wdata;
			end
		end
	end
endmodule

/* File: sim/tb_top.sv */
/* Self-checking bench for cls_controller.
   Assumes the bus model and the checker in sim/. */
`timescale 1ns/1ps
module tb_top
	import cls_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, iu_req_valid = 1'b0, snp_valid = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, iu_rdata, bus_rdata, snp_rdata, wr_data, r;
	logic pready, pslverr, iu_ready, iu_done, bus_req, bus_ack, snp_ready, snp_done, memory_inhibit, e;
	cls_iu_req_t iu_req = '0;
	cls_snp_req_t snp_req = '0;
	cls_bus_cmd_t bus_cmd;
	int beats, b0, failures = 0, check_count = 0;
	cls_controller #(.SETS(4)) dut (.*);
	cls_bus_model bus (.*);
	always #20 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	// Shared compare, bus and closing tasks.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		// One idle edge, so that a following call does not drive psel twice in one time step.
		@(posedge pclk);
	endtask
	task automatic iu_op(input logic ins, input logic w, input logic p, input cls_op_t op, input logic [31:0] a, d);
		int n = 0;
		iu_req_valid <= 1'b1;
		iu_req <= '{ins, w, p, op, a, d};
		do @(posedge pclk); while (iu_ready !== 1'b1);
		iu_req_valid <= 1'b0;
		do begin @(posedge pclk); n++; end while (iu_done !== 1'b1 && n < 300);
		check(iu_done, 1'b1);
	endtask
	task automatic snoop(input logic w, input logic [1:0] c, input logic [31:0] a, input logic inh, input logic [31:0] d);
		snp_valid <= 1'b1;
		snp_req <= '{w, c, a};
		do @(posedge pclk); while (snp_ready !== 1'b1);
		snp_valid <= 1'b0;
		@(posedge pclk);
		check(memory_inhibit, inh);
		check(snp_rdata, d);
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Scenarios: fills and hits, snoops, victims, maintenance ops, instruction side.
	task automatic t_data;
		apb(1'b0, OFF_CTRL, 32'h0);
		check(r, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		check(e, 1'b1);
		b0 = beats;
		iu_op(1'b0, 1'b0, 1'b1, OP_ACCESS, 32'h100, 32'h0);
		check(iu_rdata, 32'h5A000100);
		iu_op(1'b0, 1'b1, 1'b1, OP_ACCESS, 32'h100, 32'h11);
		check(beats - b0, 32'h4);
		snoop(1'b0, SC_LEAVE_DIRTY, 32'h100, 1'b1, 32'h11);
		snoop(1'b0, SC_INVALIDATE, 32'h100, 1'b1, 32'h11);
		snoop(1'b0, SC_LEAVE_DIRTY, 32'h100, 1'b0, 32'h0);
		iu_op(1'b0, 1'b1, POLICY_WRITETHROUGH, OP_ACCESS, 32'h200, 32'h22);
		check(wr_data, 32'h22);
		$display("data done");
	endtask
	task automatic t_victim;
		b0 = beats;
		for (int i = 0; i < 5; i++) iu_op(1'b0, 1'b1, 1'b1, OP_ACCESS, 32'h300 + i * 64, i);
		iu_op(1'b0, 1'b0, 1'b1, OP_ACCESS, 32'h400, 32'h0);
		check(beats - b0, 32'h15);
		check(iu_rdata, 32'h4);
		b0 = beats;
		iu_op(1'b0, 1'b0, 1'b1, OP_CACHE_INVALIDATE_OP, 32'h400, 32'h0);
		snoop(1'b0, SC_LEAVE_DIRTY, 32'h400, 1'b0, 32'h0);
		iu_op(1'b0, 1'b1, 1'b1, OP_ACCESS, 32'h440, 32'h44);
		iu_op(1'b0, 1'b0, 1'b1, OP_CACHE_WRITEBACK_INVALIDATE_OP, 32'h440, 32'h0);
		iu_op(1'b0, 1'b0, 1'b1, OP_CACHE_WRITEBACK_INVALIDATE_OP, 32'h440, 32'h0);
		check(beats - b0, 32'h5);
		check(wr_data, 32'h44);
		b0 = beats;
		iu_op(1'b1, 1'b0, 1'b1, OP_ACCESS, 32'h500, 32'h0);
		snoop(1'b0, SC_LEAVE_DIRTY, 32'h500, 1'b0, 32'h0);
		iu_op(1'b1, 1'b0, 1'b1, OP_ACCESS, 32'h500, 32'h0);
		check(beats - b0, 32'h4);
		snoop(1'b1, SC_LEAVE_DIRTY, 32'h500, 1'b0, 32'h0);
		iu_op(1'b1, 1'b0, 1'b1, OP_ACCESS, 32'h500, 32'h0);
		check(beats - b0, 32'h8);
		// A flush drops every line, so the instruction line must be fetched again.
		apb(1'b1, OFF_CTRL, 32'h3);
		iu_op(1'b1, 1'b0, 1'b1, OP_ACCESS, 32'h500, 32'h0);
		check(beats - b0, 32'hC);
		apb(1'b0, OFF_HITS, 32'h0);
		check(r, 32'h3);
		$display("victim done");
	endtask
	// Reset, run, and a watchdog far beyond the expected few hundred cycles.
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_data();
		t_victim();
		finish_test();
	end
	initial begin
		#200000;
		failures++;
		finish_test();
	end
endmodule
bind cls_controller cls_chk u_chk (.*);
